// File: bvp_ctrl.sv
// Notes on behaviour
// - strobe only after command word is set
// - strobe held low at least 500 ns; o_strobe here is held high for 13 cycles, 520 ns at 25 MHz
// - strobe starts with high to low edge; o_strobe here starts with a low to high edge
// - hold is the logic one level
`timescale 1ns/1ns
`default_nettype none
module bvp_ctrl
   import bvp_pkg::*;
#(
   parameter int STROBE_CYC = BVP_STROBE_CYC
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // port lines, logic one means asserted
   output bvp_cmd_t o_cmd,
   output logic o_strobe,
   output logic o_ext_ref,
   output logic o_standby,
   input wire logic i_overload,
   input wire logic i_not_ready,
   // interrupt
   output logic o_irq
);
   // elaboration check: the strobe counter is eight bits wide
   if (STROBE_CYC < 1 || STROBE_CYC > 255)
   begin : g_bad_strobe_cyc
      $error("STROBE_CYC out of range");
   end

   // pin synchronisers, three stages each
   logic [2:0] ovl_sync_reg;
   logic [2:0] nrdy_sync_reg;
   logic ovl_reg;
   logic nrdy_reg;
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ovl_sync_reg <= 3'h0;
         nrdy_sync_reg <= 3'h0;
         ovl_reg <= 1'b0;
         nrdy_reg <= 1'b0;
      end
      else
      begin
         ovl_sync_reg <= {ovl_sync_reg[1:0], i_overload};
         nrdy_sync_reg <= {nrdy_sync_reg[1:0], i_not_ready};
         if (ovl_sync_reg[1] == ovl_sync_reg[2])
            ovl_reg <= ovl_sync_reg[2];
         if (nrdy_sync_reg[1] == nrdy_sync_reg[2])
            nrdy_reg <= nrdy_sync_reg[2];
      end
   end

   // register state
   logic [16:0] cmd_reg;
   logic [3:0] ctrl_reg;
   logic [2:0] irq_reg;
   logic [2:0] mask_reg;
   bvp_state_t state_reg;
   bvp_state_t state_next;
   logic [7:0] cnt_reg;
   logic nrdy_d_reg;

   // apb decode, single wait-free access
   wire acc = i_psel && i_penable;
   wire wr = acc && i_pwrite;
   wire hit_cmd = i_paddr == BVP_OFF_CMD;
   wire hit_ctrl = i_paddr == BVP_OFF_CTRL;
   wire hit_stat = i_paddr == BVP_OFF_STAT;
   wire hit_irq = i_paddr == BVP_OFF_IRQ;
   wire hit_mask = i_paddr == BVP_OFF_MASK;
   wire hit_any = hit_cmd | hit_ctrl | hit_stat | hit_irq | hit_mask;
   wire cmd_wr = wr && hit_cmd;
   wire direct = ctrl_reg[BVP_CTRL_DIRECT_POS];
   wire busy = state_reg != BVP_IDLE;
   wire [31:0] stat_word = {28'h0, busy, nrdy_reg, ovl_reg, direct};
   wire [31:0] rd_mux =
      hit_cmd ? {15'h0, cmd_reg} :
      hit_ctrl ? {28'h0, ctrl_reg} :
      hit_stat ? stat_word :
      hit_irq ? {29'h0, irq_reg} :
      hit_mask ? {29'h0, mask_reg} : 32'h0;

   // events: strobe done, not-ready fell, overload rose
   logic ovl_d_reg;
   wire ev_done = state_reg == BVP_WAIT; // strobe pin is still high in this cycle and drops at the next edge
   wire ev_ready = nrdy_d_reg && !nrdy_reg;
   wire ev_ovl = ovl_reg && !ovl_d_reg;
   wire [2:0] ev_vec = {ev_ovl, ev_ready, ev_done};
   wire [2:0] irq_clr = (wr && hit_irq) ? i_pwdata[2:0] : 3'h0;

   // isolated mode sequencer: setup, strobe high, then wait
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         BVP_IDLE:
            if (cmd_wr && !direct)
               state_next = BVP_SETUP;
         BVP_SETUP:
            state_next = BVP_STROBE;
         BVP_STROBE:
            if (cnt_reg == 8'h01)
               state_next = BVP_WAIT;
         BVP_WAIT:
            state_next = BVP_IDLE;
         default:
            state_next = BVP_IDLE;
      endcase
   end

   // registers and sequencer
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cmd_reg <= BVP_CMD_RST;
         ctrl_reg <= BVP_CTRL_RST;
         mask_reg <= BVP_MASK_RST;
         irq_reg <= 3'h0;
         state_reg <= BVP_IDLE;
         cnt_reg <= 8'h00;
         nrdy_d_reg <= 1'b0;
         ovl_d_reg <= 1'b0;
      end
      else
      begin
         // writes to cmd during a strobe are dropped to keep data stable
         if (cmd_wr && !busy)
            cmd_reg <= i_pwdata[16:0];
         if (wr && hit_ctrl)
            ctrl_reg <= i_pwdata[3:0];
         if (wr && hit_mask)
            mask_reg <= i_pwdata[2:0];
         irq_reg <= (irq_reg & ~irq_clr) | ev_vec; // set wins over clear
         state_reg <= state_next;
         cnt_reg <= (state_next == BVP_STROBE && state_reg != BVP_STROBE) ?
            8'(STROBE_CYC) : (cnt_reg != 8'h00 ? cnt_reg - 8'h01 : 8'h00);
         nrdy_d_reg <= nrdy_reg;
         ovl_d_reg <= ovl_reg;
      end
   end

   // outputs, all from flip-flops
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_cmd <= bvp_cmd_t'(BVP_CMD_RST);
         o_strobe <= 1'b0;
         o_ext_ref <= 1'b0;
         o_standby <= 1'b1;
         o_prdata <= 32'h0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_irq <= 1'b0;
      end
      else
      begin
         // direct mode: cmd lines follow register, hold bit freezes output
         // isolated: command lands one cycle before the strobe, so it is valid first
         if (direct || state_reg == BVP_SETUP)
            o_cmd <= bvp_cmd_t'(cmd_reg);
         o_strobe <= direct ? ctrl_reg[BVP_CTRL_HOLD_POS] :
            (state_reg == BVP_STROBE);
         o_ext_ref <= ctrl_reg[BVP_CTRL_EXTREF_POS];
         o_standby <= ctrl_reg[BVP_CTRL_STBY_POS];
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : o_prdata;
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !hit_any;
         o_irq <= |(((irq_reg & ~irq_clr) | ev_vec) & mask_reg);
      end
   end

   // helper: length of the current strobe pulse, saturating; too long for a repetition
   logic [7:0] hi_cnt_reg;
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         hi_cnt_reg <= 8'h00;
      else if (!o_strobe)
         hi_cnt_reg <= 8'h00;
      else if (hi_cnt_reg != 8'hff)
         hi_cnt_reg <= hi_cnt_reg + 8'h01;
   end

   // strobe stays asserted for the full programmed width
   property p_strobe_width;
      @(posedge i_clock) disable iff (!i_rstn)
      (!direct && $fell(o_strobe)) |-> hi_cnt_reg == 8'(STROBE_CYC);
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("strobe width wrong");

   // strobe rises only with the command already standing on the pins
   property p_strobe_after_cmd;
      @(posedge i_clock) disable iff (!i_rstn)
      (!direct && $rose(o_strobe)) |-> $stable(o_cmd) && o_cmd == bvp_cmd_t'(cmd_reg);
   endproperty
   a_strobe_after_cmd: assert property (p_strobe_after_cmd)
      else $error("strobe without command");

   // command pins steady while isolated strobe is asserted
   property p_cmd_stable;
      @(posedge i_clock) disable iff (!i_rstn)
      (!direct && o_strobe && $past(o_strobe)) |-> $stable(o_cmd);
   endproperty
   a_cmd_stable: assert property (p_cmd_stable)
      else $error("command changed during strobe");

   // direct mode: command pins follow the register one cycle later
   property p_direct_track;
      @(posedge i_clock) disable iff (!i_rstn)
      $past(direct) |-> o_cmd == bvp_cmd_t'($past(cmd_reg));
   endproperty
   a_direct_track: assert property (p_direct_track)
      else $error("direct command not tracking");

   // standby pin follows its control bit one cycle later
   property p_standby;
      @(posedge i_clock) disable iff (!i_rstn)
      $changed(ctrl_reg) |=> o_standby == $past(ctrl_reg[BVP_CTRL_STBY_POS]);
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby pin wrong");
endmodule // bvp_ctrl
`default_nettype wire

// File: bvp_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module bvp_ctrl_tb
   import bvp_pkg::*;
;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, ready, err, irq, strobe, xref, stby;
   logic ovl, nrdy, short_ld = 0, xsel, direct = 0;
   logic [7:0] addr = '0;
   logic [31:0] wd = '0, prd, rd;
   bvp_cmd_t cmd, lvl, pre;
   int n_mismatch = 0, comparisons = 0, cyc = 0, n;
   bvp_ctrl uut (.i_clock(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd), .o_pready(ready), .o_pslverr(err),
      .o_cmd(cmd), .o_strobe(strobe), .o_ext_ref(xref), .o_standby(stby),
      .i_overload(ovl), .i_not_ready(nrdy), .o_irq(irq));
   bvp_dev_model dev (.i_clock(clk), .i_cmd(cmd), .i_strobe(strobe), .i_direct(direct),
      .i_standby(stby), .i_ext_ref(xref), .i_load_short(short_ld), .o_overload(ovl),
      .o_not_ready(nrdy), .o_ext_sel(xsel), .o_level(lvl));
   // clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("done: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one apb transfer: request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (ready !== 1'b1);
      rd = prd;
      `CHK("pslverr", (a > BVP_OFF_MASK), err)
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic idle(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic t_reset();
      `CHK("standby", 1'b1, stby)
      `CHK("strobe idle", 1'b0, strobe)
      apb(1'b0, BVP_OFF_CTRL, 32'h0);
      `CHK("ctrl", 32'h2, rd)
      apb(1'b0, 8'h14, 32'h0); // unmapped
      $display("test reset done");
   endtask
   task automatic t_isolated();
      apb(1'b1, BVP_OFF_CTRL, 32'h0);
      apb(1'b1, BVP_OFF_CMD, 32'h1fa90);
      n = 0;
      pre = cmd;
      while (strobe !== 1'b1 && n < 10)
      begin
         pre = cmd;
         idle(1);
         n++;
      end
      `CHK("cmd before strobe", 17'h1fa90, pre)
      `CHK("cmd at strobe", 17'h1fa90, cmd)
      n = 0;
      while (strobe === 1'b1 && n < 300)
      begin
         idle(1);
         n++;
      end
      `CHK("strobe long", 1'b1, n * 40 >= 500)
      `CHK("strobe cycles", BVP_STROBE_CYC, n)
      `CHK("level", 17'h1fa90, lvl)
      apb(1'b0, BVP_OFF_STAT, 32'h0);
      `CHK("settling", 1'b1, rd[2])
      idle(50);
      apb(1'b0, BVP_OFF_STAT, 32'h0);
      `CHK("ready", 1'b0, rd[2])
      apb(1'b0, BVP_OFF_IRQ, 32'h0);
      `CHK("irq bits", 2'b11, rd[1:0])
      `CHK("masked irq", 1'b0, irq)
      apb(1'b1, BVP_OFF_IRQ, 32'h3);
      $display("test isolated done");
   endtask
   task automatic t_direct();
      direct <= 1'b1;
      apb(1'b1, BVP_OFF_CTRL, 32'hc);
      apb(1'b1, BVP_OFF_CMD, 32'h01234);
      idle(3);
      `CHK("held", 17'h1fa90, lvl)
      `CHK("hold pin", 1'b1, strobe)
      apb(1'b1, BVP_OFF_CTRL, 32'h4);
      idle(3);
      `CHK("released", 17'h01234, lvl)
      apb(1'b1, BVP_OFF_CMD, 32'h10005);
      idle(3);
      `CHK("tracking", 17'h10005, lvl)
      $display("test direct done");
   endtask
   task automatic t_modes();
      apb(1'b1, BVP_OFF_CTRL, 32'h7);
      idle(2);
      `CHK("ext ref", 1'b1, xsel)
      `CHK("standby out", 17'h0, lvl)
      apb(1'b1, BVP_OFF_CTRL, 32'h4);
      idle(2);
      `CHK("int ref", 1'b0, xsel)
      `CHK("operate out", 17'h10005, lvl)
      $display("test modes done");
   endtask
   task automatic t_overload();
      apb(1'b1, BVP_OFF_MASK, 32'h4);
      short_ld <= 1'b1;
      idle(8);
      apb(1'b0, BVP_OFF_STAT, 32'h0);
      `CHK("ovl stat", 1'b1, rd[1])
      `CHK("irq on", 1'b1, irq)
      apb(1'b1, BVP_OFF_IRQ, 32'h4);
      idle(2);
      `CHK("irq cleared", 1'b0, irq)
      short_ld <= 1'b0;
      idle(8);
      apb(1'b0, BVP_OFF_STAT, 32'h0);
      `CHK("ovl gone", 1'b0, rd[1])
      $display("test overload done");
   endtask
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1;
      t_reset();
      t_isolated();
      t_direct();
      t_modes();
      t_overload();
      complete_run();
   end
endmodule // bvp_ctrl_tb
`default_nettype wire

// File: bvp_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module bvp_dev_model
   import bvp_pkg::*;
#(
   parameter int SETTLE = 30
)
(
   // clock
   input wire logic i_clock,
   // command lines, logic one asserted
   input wire bvp_cmd_t i_cmd,
   input wire logic i_strobe,
   input wire logic i_direct,
   input wire logic i_standby,
   input wire logic i_ext_ref,
   input wire logic i_load_short,
   // response and observed output
   output logic o_overload,
   output logic o_not_ready,
   output logic o_ext_sel,
   output bvp_cmd_t o_level
);
   bvp_cmd_t held_reg = '0;
   logic strobe_reg = 1'b0;
   int settle_reg = 0;
   // isolated: leading edge only; direct: follow unless held
   wire take = i_direct ? !i_strobe : (i_strobe && !strobe_reg);
   // clocked sampling stands in for the analog path
   always @(posedge i_clock)
   begin
      strobe_reg <= i_strobe;
      if (take && i_cmd != held_reg)
         settle_reg <= SETTLE;
      else if (settle_reg > 0)
         settle_reg <= settle_reg - 1;
      if (take)
         held_reg <= i_cmd;
   end
   // response lines
   assign o_level = i_standby ? '0 : held_reg;
   assign o_not_ready = (settle_reg != 0);
   assign o_overload = i_load_short;
   assign o_ext_sel = i_ext_ref;
endmodule // bvp_dev_model
`default_nettype wire

// File: bvp_pkg.sv
package bvp_pkg;
   // apb register byte offsets
   localparam logic [7:0] BVP_OFF_CMD = 8'h00;
   localparam logic [7:0] BVP_OFF_CTRL = 8'h04;
   localparam logic [7:0] BVP_OFF_STAT = 8'h08;
   localparam logic [7:0] BVP_OFF_IRQ = 8'h0c;
   localparam logic [7:0] BVP_OFF_MASK = 8'h10;
   // cmd register fields
   localparam int BVP_CMD_SIGN_POS = 16;
   // ctrl register fields
   localparam int BVP_CTRL_EXTREF_POS = 0;
   localparam int BVP_CTRL_STBY_POS = 1;
   localparam int BVP_CTRL_DIRECT_POS = 2;
   localparam int BVP_CTRL_HOLD_POS = 3;
   // irq bit positions
   localparam int BVP_IRQ_DONE_POS = 0;
   localparam int BVP_IRQ_READY_POS = 1;
   localparam int BVP_IRQ_OVL_POS = 2;
   // reset values
   localparam logic [16:0] BVP_CMD_RST = 17'h00000;
   localparam logic [3:0] BVP_CTRL_RST = 4'h2;
   localparam logic [2:0] BVP_MASK_RST = 3'h0;
   // timing: strobe low time and cycle count at 25 MHz
   localparam int BVP_CLK_HZ = 25000000;
   localparam int BVP_STROBE_NS = 500;
   localparam int BVP_STROBE_CYC =
      (BVP_STROBE_NS * (BVP_CLK_HZ / 1000000) + 999) / 1000;
   // command word to the port
   typedef struct packed
   {
      logic sign;
      logic [3:0] dec_a;
      logic [3:0] dec_b;
      logic [3:0] dec_c;
      logic [3:0] dec_d;
   } bvp_cmd_t;
   // sequencer states
   typedef enum logic [1:0]
   {
      BVP_IDLE = 2'b00,
      BVP_SETUP = 2'b01,
      BVP_STROBE = 2'b10,
      BVP_WAIT = 2'b11
   } bvp_state_t;
endpackage
